// [rtl/sdil_pkg.sv]
package sdil_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_CH  = 6;
  localparam int CODE_W  = 10;
  localparam int IDX_W   = 3;
  localparam int PIN_W   = 17;
  // ==========================================================
  // Channel order and codes
  localparam logic [2:0] CH_LEFT   = 3'h0;
  localparam logic [2:0] CH_RIGHT  = 3'h5;
  localparam logic [2:0] CNT_FULL  = 3'h6;
  localparam logic [9:0] CODE_MAX  = 10'h3ff;
  localparam logic [9:0] CODE_RST  = 10'h000;
  // ==========================================================
  // Pin vector positions
  localparam int P_CLK     = 0;
  localparam int P_DAT     = 1;
  localparam int P_START   = 11;
  localparam int P_DIR     = 12;
  localparam int P_EDGE    = 13;
  localparam int P_XFER    = 14;
  localparam int P_POL     = 15;
  localparam int P_STANDBY = 16;
endpackage

// [rtl/sdil_sync.sv]
`timescale 1ns/100ps
module sdil_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_b_in,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================
  // Three stages, level accepted when stages two and three agree
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      level_out <= '0;
    else
      level_out <= (s2_q & s3_q) | (level_out & (s2_q | s3_q));
  end
endmodule // sdil_sync

// [rtl/sdil_loader.sv]
`timescale 1ns/100ps
module sdil_loader
  import sdil_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk_in,
  input  wire logic               rst_b_in,
  // Controller pins
  input  wire logic               pix_clk_in,
  input  wire logic [CODE_W-1:0]  pixel_code_in,
  input  wire logic               sequence_start_in,
  input  wire logic               dir_sel_in,
  input  wire logic               edge_sel_in,
  input  wire logic               output_transfer_in,
  input  wire logic               polarity_sel_in,
  input  wire logic               standby_in,
  // Channel codes
  output logic      [CODE_W-1:0]  column0_out,
  output logic      [CODE_W-1:0]  column1_out,
  output logic      [CODE_W-1:0]  column2_out,
  output logic      [CODE_W-1:0]  column3_out,
  output logic      [CODE_W-1:0]  column4_out,
  output logic      [CODE_W-1:0]  column5_out,
  // Status
  output logic                    drive_above_mid_out,
  output logic                    debias_out,
  output logic                    loading_out
);
  logic [PIN_W-1:0]          lvl;
  logic                      clk_prev_q;
  logic                      rise;
  logic                      fall;
  logic                      act_edge;
  logic                      arm_q;
  logic                      dir_q;
  logic [IDX_W-1:0]          idx_q;
  logic [IDX_W-1:0]          cnt_q;
  logic                      xfer_det_q;
  logic [CODE_W-1:0]         lat_q [NUM_CH];
  logic [CODE_W-1:0]         col_q [NUM_CH];
  logic [NUM_CH*CODE_W-1:0]  lat_flat;
  logic [NUM_CH*CODE_W-1:0]  col_flat;

  function automatic logic [IDX_W-1:0] first_ch(input logic dir);
    first_ch = dir ? CH_RIGHT : CH_LEFT;
  endfunction

  function automatic logic [IDX_W-1:0] step(input logic [IDX_W-1:0] i,
                                            input logic dir);
    step = dir ? i - 3'h1 : i + 3'h1;
  endfunction

  // ==========================================================
  // Pin synchronisers
  sdil_sync #(.W(PIN_W)) u_sync (
    .mclk_in   (mclk_in),
    .rst_b_in  (rst_b_in),
    .pin_in    ({standby_in, polarity_sel_in, output_transfer_in,
                 edge_sel_in, dir_sel_in, sequence_start_in,
                 pixel_code_in, pix_clk_in}),
    .level_out (lvl)
  );

  // ==========================================================
  // Pin clock edges
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      clk_prev_q <= 1'b0;
    else
      clk_prev_q <= lvl[P_CLK];
  end

  assign rise     = lvl[P_CLK] & ~clk_prev_q;
  assign fall     = ~lvl[P_CLK] & clk_prev_q;
  assign act_edge = lvl[P_EDGE] ? rise : fall;

  // ==========================================================
  // Sequence control
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      arm_q <= 1'b0;
    else if (act_edge)
      arm_q <= lvl[P_START];
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      dir_q <= 1'b0;
      idx_q <= CH_LEFT;
      cnt_q <= CNT_FULL;
    end
    else if (act_edge && arm_q)
    begin
      dir_q <= lvl[P_DIR];
      idx_q <= step(first_ch(lvl[P_DIR]), lvl[P_DIR]);
      cnt_q <= 3'h1;
    end
    else if (act_edge && cnt_q != CNT_FULL)
    begin
      idx_q <= step(idx_q, dir_q);
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign loading_out = (cnt_q != CNT_FULL);

  // ==========================================================
  // Channel latches and output stage
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      always_ff @(posedge mclk_in)
      begin
        if (!rst_b_in)
          lat_q[c] <= CODE_RST;
        else if (act_edge && arm_q && first_ch(lvl[P_DIR]) == c)
          lat_q[c] <= lvl[P_DAT +: CODE_W];
        else if (act_edge && !arm_q && cnt_q != CNT_FULL && idx_q == c)
          lat_q[c] <= lvl[P_DAT +: CODE_W];
      end

      always_ff @(posedge mclk_in)
      begin
        if (!rst_b_in)
          col_q[c] <= CODE_RST;
        else if (rise && xfer_det_q)
          col_q[c] <= lat_q[c];
      end

      assign lat_flat[c*CODE_W +: CODE_W] = lat_q[c];
      assign col_flat[c*CODE_W +: CODE_W] = col_q[c];
    end
  endgenerate

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      xfer_det_q <= 1'b0;
    else if (rise)
      xfer_det_q <= lvl[P_XFER];
  end

  assign column0_out = col_q[0];
  assign column1_out = col_q[1];
  assign column2_out = col_q[2];
  assign column3_out = col_q[3];
  assign column4_out = col_q[4];
  assign column5_out = col_q[5];

  // ==========================================================
  // Static controls
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      drive_above_mid_out <= 1'b0;
      debias_out          <= 1'b0;
    end
    else
    begin
      drive_above_mid_out <= lvl[P_POL];
      debias_out          <= lvl[P_STANDBY];
    end
  end

  // ==========================================================
  // Checks
  property p_start_sample;
    @(posedge mclk_in) disable iff (!rst_b_in)
    act_edge |=> (arm_q == $past(lvl[P_START]));
  endproperty
  a_start_sample: assert property (p_start_sample)
    else $error("start not sampled on active edge");

  property p_seq_begin;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (act_edge && arm_q) |=> (cnt_q == 3'h1 && loading_out);
  endproperty
  a_seq_begin: assert property (p_seq_begin)
    else $error("sequence did not begin after start");

  property p_dir_left;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (act_edge && arm_q && !lvl[P_DIR])
      |=> (lat_q[0] == $past(lvl[P_DAT +: CODE_W]) && idx_q == 3'h1);
  endproperty
  a_dir_left: assert property (p_dir_left)
    else $error("left sequence did not load channel 0");

  property p_dir_right;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (act_edge && arm_q && lvl[P_DIR])
      |=> (lat_q[5] == $past(lvl[P_DAT +: CODE_W]) && idx_q == 3'h4);
  endproperty
  a_dir_right: assert property (p_dir_right)
    else $error("right sequence did not load channel 5");

  property p_load_edge;
    @(posedge mclk_in) disable iff (!rst_b_in)
    !act_edge |=> $stable(lat_flat);
  endproperty
  a_load_edge: assert property (p_load_edge)
    else $error("latch changed off the active edge");

  property p_xfer_rise;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (fall && !rise) |=> $stable(xfer_det_q);
  endproperty
  a_xfer_rise: assert property (p_xfer_rise)
    else $error("transfer sampled on falling edge");

  property p_xfer_apply;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (rise && xfer_det_q) |=> (col_flat == $past(lat_flat));
  endproperty
  a_xfer_apply: assert property (p_xfer_apply)
    else $error("outputs did not take latched words");

  property p_hold;
    @(posedge mclk_in) disable iff (!rst_b_in)
    !(rise && xfer_det_q) |=> $stable(col_flat);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs changed without transfer");

  property p_polarity;
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(lvl[P_POL]) |=> drive_above_mid_out;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("polarity not followed");

  property p_standby;
    @(posedge mclk_in) disable iff (!rst_b_in)
    lvl[P_STANDBY] |=> debias_out;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not followed");

  c_left:  cover property (@(posedge mclk_in)
                           act_edge && arm_q && !lvl[P_DIR]);
  c_right: cover property (@(posedge mclk_in) act_edge && arm_q && lvl[P_DIR]);
  c_full:  cover property (@(posedge mclk_in) $rose(cnt_q == CNT_FULL));
  c_xfer:  cover property (@(posedge mclk_in) rise && xfer_det_q);
endmodule // sdil_loader

// [tb/sdil_ctrl_model.sv]
`timescale 1ns/100ps
module sdil_ctrl_model
  import sdil_pkg::*;
(
  // Clock
  input  wire logic              mclk_in,
  // Controller pins
  output logic                   pix_clk_out,
  output logic [CODE_W-1:0]      pixel_code_out,
  output logic                   sequence_start_out,
  output logic                   output_transfer_out
);
  // ==========================================================
  // Idle pins, clock stands low
  initial
  begin
    pix_clk_out         = 1'b0;
    pixel_code_out      = CODE_RST;
    sequence_start_out  = 1'b0;
    output_transfer_out = 1'b0;
  end

  // ==========================================================
  // Half period of the pixel clock
  task automatic half(input logic lvl);
    repeat (8) @(negedge mclk_in);
    pix_clk_out = lvl;
  endtask

  // ==========================================================
  // Start, six words, then transfer
  task automatic send_frame(input logic act,
                            input logic [6*CODE_W-1:0] words);
    int i;
    half(~act);
    sequence_start_out = 1'b1;
    half(act);
    for (i = 0; i < NUM_CH; i++)
    begin
      half(~act);
      sequence_start_out = 1'b0;
      pixel_code_out     = words[i*CODE_W +: CODE_W];
      half(act);
    end
    half(1'b0);
    pixel_code_out      = ~pixel_code_out;
    output_transfer_out = 1'b1;
    half(1'b1);
    half(1'b0);
    output_transfer_out = 1'b0;
    half(1'b1);
    half(1'b0);
  endtask
endmodule // sdil_ctrl_model

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
  import sdil_pkg::*;
  logic                  mclk_in, rst_b_in, pix_clk, start, xfer;
  logic                  dir_sel, edge_sel, pol, standby;
  logic                  above, debias, loading;
  logic [CODE_W-1:0]     code, c0, c1, c2, c3, c4, c5;
  logic [6*CODE_W-1:0]   exp_q [$];
  logic [6*CODE_W-1:0]   words, exp_v, seen, prev;
  int                    n_fail, checks, i, k, ch, n_load;

  sdil_loader uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .pix_clk_in(pix_clk), .pixel_code_in(code),
    .sequence_start_in(start), .dir_sel_in(dir_sel),
    .edge_sel_in(edge_sel), .output_transfer_in(xfer),
    .polarity_sel_in(pol), .standby_in(standby),
    .column0_out(c0), .column1_out(c1), .column2_out(c2),
    .column3_out(c3), .column4_out(c4), .column5_out(c5),
    .drive_above_mid_out(above), .debias_out(debias),
    .loading_out(loading));
  sdil_ctrl_model ctrl (.mclk_in(mclk_in), .pix_clk_out(pix_clk),
    .pixel_code_out(code), .sequence_start_out(start),
    .output_transfer_out(xfer));

  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  assign seen = {c5, c4, c3, c2, c1, c0};

  // ==========================================================
  // Compare and verdict
  task automatic check(input logic [6*CODE_W-1:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Output watcher, one note per change
  always @(negedge mclk_in)
  begin
    if (rst_b_in === 1'b1 && seen !== prev)
    begin
      if (exp_q.size() == 0)
        check(seen, prev);
      else
        check(seen, exp_q.pop_front());
    end
    prev <= seen;
  end

  // Cycles spent loading, one frame at a time
  always @(negedge mclk_in)
  begin
    if (loading === 1'b1)
      n_load++;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 0, 1);
    print_verdict;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    n_fail   = 0;
    checks   = 0;
    rst_b_in = 1'b0;
    dir_sel  = 1'b0;
    edge_sel = 1'b1;
    pol      = 1'b0;
    standby  = 1'b0;
    void'($urandom(32'h9840));
    repeat (2) @(negedge mclk_in);
    rst_b_in = 1'b1;
    @(negedge mclk_in);
    check(seen, '0);
    for (k = 0; k < 6; k++)
    begin
      @(negedge mclk_in);
      dir_sel  = k[0];
      edge_sel = k[1];
      pol      = 1'($urandom);
      standby  = 1'($urandom);
      for (i = 0; i < NUM_CH; i++)
      begin
        words[i*CODE_W +: CODE_W] = (k >= 4) ?
          ((i % 2) ? CODE_MAX : CODE_RST) : CODE_W'($urandom);
        ch = dir_sel ? 5 - i : i;
        exp_v[ch*CODE_W +: CODE_W] = words[i*CODE_W +: CODE_W];
      end
      exp_q.push_back(exp_v);
      n_load = 0;
      ctrl.send_frame(edge_sel, words);
      for (i = 0; i < 200 && exp_q.size() != 0; i++)
        @(negedge mclk_in);
      if (exp_q.size() != 0)
      begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, seen, exp_v);
        break;
      end
      check(60'({above, debias, loading}), 60'({pol, standby, 1'b0}));
      check(60'(debias), 60'(standby));
      check(60'(n_load), 60'(80));
      $display("test %0d done", k);
    end
    print_verdict;
  end
endmodule // tb
